// >>> rtl/epc_defines.svh
// Constants for the nonvolatile program control block: offsets, fields,
// reset values and timing counts. Assumes a 250 MHz aclk.
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

`define EPC_OFF_CTRL        8'h00
`define EPC_OFF_ADDR        8'h04
`define EPC_OFF_DATA        8'h08
`define EPC_OFF_STATUS      8'h0C

`define EPC_BIT_READ        0
`define EPC_BIT_TRIG        1
`define EPC_BIT_ARM         2
`define EPC_BIT_RIE         3
`define EPC_BIT_MODE_LO     4
`define EPC_BIT_MODE_HI     5

`define EPC_RST_MODE        2'h0
`define EPC_RST_DATA        8'h00

`define EPC_CLK_MHZ         250
`define EPC_T_ATOMIC_US     3400
`define EPC_T_SPLIT_US      1800
`define EPC_CYC_ATOMIC      (`EPC_T_ATOMIC_US * `EPC_CLK_MHZ)
`define EPC_CYC_SPLIT       (`EPC_T_SPLIT_US * `EPC_CLK_MHZ)
`define EPC_ARM_CYCLES      3'h4
`define EPC_PROG_STALL      3'h2
`define EPC_READ_STALL      3'h4

`endif

// >>> rtl/epc_pkg.sv
// Types for the nonvolatile program control block.
// Assumes epc_defines.svh supplies the numeric constants.
package epc_pkg;
    typedef enum logic [1:0] {
        EPC_MODE_ATOMIC = 2'h0,
        EPC_MODE_ERASE  = 2'h1,
        EPC_MODE_WRITE  = 2'h2,
        EPC_MODE_RSVD   = 2'h3
    } epc_mode_e;
    typedef enum logic [2:0] {
        EPC_ST_IDLE  = 3'h1,
        EPC_ST_PROG  = 3'h2,
        EPC_ST_STALL = 3'h4
    } epc_state_e;
endpackage

// >>> rtl/epc_ctrl.sv
// Nonvolatile data memory program control with an AXI4-Lite register port.
// Assumes a single aclk domain and a CPU that honours cpu_stall.
//
// Behaviour
// RQ1: Mode field picks atomic, erase or write.
// RQ2: Mode writes ignored while trigger flag set.
// RQ3: Reset clears mode unless programming runs.
// RQ4: Ready request needs enable and global enable.
// RQ5: Ready request is a level while idle.
// RQ6: Trigger works only within four cycles of arm.
// RQ7: Hardware clears arm after four cycles.
// RQ8: Trigger flag clears when program time elapses.
// RQ9: Accepted trigger stalls CPU two cycles.
// RQ10: Read strobe fetches addressed byte into data.
// RQ11: Read strobe stalls CPU four cycles; a read in the same write as an accepted trigger stalls it two.
// RQ12: Busy blocks reads and address writes.
// RQ13: Software polls trigger flag before reading.
// RQ14: Address is nine bits, written before use.
// RQ15: Data register feeds writes, receives reads.
// RQ16: Reserved mode trigger clears flag promptly.
`timescale 1ns/100ps
`include "epc_defines.svh"

module epc_ctrl
    import epc_pkg::*;
#(
    parameter int unsigned CYC_ATOMIC = `EPC_CYC_ATOMIC,
    parameter int unsigned CYC_SPLIT  = `EPC_CYC_SPLIT
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        global_irq_enable,
    output logic             ready_irq,
    output logic             cpu_stall,
    output logic [8:0]       mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             mem_erase,
    output logic             mem_write,
    output logic             mem_read,
    input  wire logic [7:0]  mem_rdata
);

    // Bus capture registers: address and data are held once taken.
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic [7:0]  ar_addr_q;
    logic        ar_have_q;

    // Block state.
    epc_state_e  state_q;
    logic [1:0]  mode_q;
    logic        rie_q;
    logic        arm_q;
    logic [2:0]  arm_cnt_q;
    logic        trig_q;
    logic [8:0]  addr_q;
    logic [7:0]  data_q;
    logic [31:0] prog_cnt_q;
    logic [2:0]  stall_cnt_q;
    logic        read_pend_q;

    // Write decode happens once both halves of a write are held.
    wire         wr_fire   = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire         wr_lane0  = wr_fire & w_strb_q[0];
    wire         wr_ctrl   = wr_lane0 & (aw_addr_q == `EPC_OFF_CTRL);
    wire         wr_addr   = wr_fire & (aw_addr_q == `EPC_OFF_ADDR);
    wire         wr_data   = wr_lane0 & (aw_addr_q == `EPC_OFF_DATA);
    wire         wr_ok     = (aw_addr_q == `EPC_OFF_CTRL) |
                             (aw_addr_q == `EPC_OFF_ADDR) |
                             (aw_addr_q == `EPC_OFF_DATA) |
                             (aw_addr_q == `EPC_OFF_STATUS);
    wire [7:0]   wb        = w_data_q[7:0];
    wire         busy      = trig_q;
    wire         prog_go   = wr_ctrl & wb[`EPC_BIT_TRIG] & arm_q & ~busy;
    wire         read_go   = wr_ctrl & wb[`EPC_BIT_READ] & ~busy;
    wire         mode_rsvd = (mode_q == EPC_MODE_RSVD);
    wire [31:0]  prog_len  = (mode_q == EPC_MODE_ATOMIC) ? CYC_ATOMIC
                                                         : CYC_SPLIT;
    wire         rd_fire   = ar_have_q & ~s_axi_rvalid;
    wire [7:0]   ctrl_rd   = {2'h0, mode_q, rie_q, arm_q, trig_q, 1'b0};
    wire         rd_ok     = (ar_addr_q == `EPC_OFF_CTRL) |
                             (ar_addr_q == `EPC_OFF_ADDR) |
                             (ar_addr_q == `EPC_OFF_DATA) |
                             (ar_addr_q == `EPC_OFF_STATUS);
    wire [31:0]  rd_word   =
        (ar_addr_q == `EPC_OFF_CTRL)   ? {24'h0, ctrl_rd} :
        (ar_addr_q == `EPC_OFF_ADDR)   ? {23'h0, addr_q} :
        (ar_addr_q == `EPC_OFF_DATA)   ? {24'h0, data_q} :
        (ar_addr_q == `EPC_OFF_STATUS) ? {30'h0, cpu_stall, busy} :
                                         32'h0;

    // Write channel handshake: one write under way at a time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2; // SLVERR if unmapped.
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: answer one cycle after the address is held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_have_q     <= 1'b0;
            ar_addr_q     <= 8'h00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~ar_have_q & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_have_q <= 1'b1;
                ar_addr_q <= {s_axi_araddr[7:2], 2'h0};
            end
            if (rd_fire) begin
                ar_have_q    <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Mode field survives a reset that lands mid-programming.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (!busy) begin
                mode_q <= `EPC_RST_MODE; // [RQ3]
            end
        end else if (wr_ctrl && !busy) begin
            mode_q <= wb[`EPC_BIT_MODE_HI:`EPC_BIT_MODE_LO]; // [RQ2]
        end
    end

    // Arm bit opens a four-cycle window, then hardware drops it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
            rie_q     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                rie_q <= wb[`EPC_BIT_RIE];
            end
            if (wr_ctrl && wb[`EPC_BIT_ARM]) begin
                arm_q     <= 1'b1;
                arm_cnt_q <= `EPC_ARM_CYCLES;
            end else if (arm_cnt_q == 3'h1) begin
                arm_q     <= 1'b0; // [RQ7]
                arm_cnt_q <= 3'h0;
            end else if (arm_cnt_q != 3'h0) begin
                arm_cnt_q <= arm_cnt_q - 3'h1;
            end
        end
    end

    // Programming sequencer; a reset mid-operation lets it finish, as the
    // array would, so only the idle path returns to its reset state.
    always_ff @(posedge aclk) begin
        if (!aresetn && !busy) begin
            state_q     <= EPC_ST_IDLE;
            trig_q      <= 1'b0;
            prog_cnt_q  <= 32'h0;
        end else begin
            case (state_q)
                EPC_ST_IDLE: begin
                    if (prog_go) begin // [RQ6]
                        trig_q     <= 1'b1;
                        prog_cnt_q <= prog_len; // [RQ1]
                        state_q    <= EPC_ST_PROG;
                    end
                end
                EPC_ST_PROG: begin
                    if (mode_rsvd || prog_cnt_q <= 32'h1) begin
                        trig_q  <= 1'b0; // [RQ8] [RQ16]
                        state_q <= EPC_ST_IDLE;
                    end else begin
                        prog_cnt_q <= prog_cnt_q - 32'h1;
                    end
                end
                default: begin
                    trig_q  <= 1'b0;
                    state_q <= EPC_ST_IDLE;
                end
            endcase
        end
    end

    // Array strobes: one-cycle pulses per accepted operation or read; a reserved mode trigger pulses none.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_erase   <= 1'b0;
            mem_write   <= 1'b0;
            mem_read    <= 1'b0;
            read_pend_q <= 1'b0;
        end else begin
            mem_erase   <= prog_go & (mode_q == EPC_MODE_ATOMIC |
                                      mode_q == EPC_MODE_ERASE); // [RQ1]
            mem_write   <= prog_go & (mode_q == EPC_MODE_ATOMIC |
                                      mode_q == EPC_MODE_WRITE);
            mem_read    <= read_go; // [RQ12]
            read_pend_q <= mem_read;
        end
    end

    // Address and data registers; busy freezes the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `EPC_RST_DATA;
            addr_q <= 9'h000; // Software must load it before any access.
        end else begin
            if (wr_addr && !busy) begin
                addr_q <= w_data_q[8:0]; // [RQ12] [RQ14]
            end
            if (read_pend_q) begin
                data_q <= mem_rdata; // [RQ10] [RQ15]
            end else if (wr_data) begin
                data_q <= wb; // [RQ15]
            end
        end
    end

    // CPU stall counter, ready interrupt and array address outputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_cnt_q <= 3'h0;
            cpu_stall   <= 1'b0;
            ready_irq   <= 1'b0;
            mem_addr    <= 9'h000;
            mem_wdata   <= 8'h00;
        end else begin
            if (prog_go) begin
                stall_cnt_q <= `EPC_PROG_STALL; // [RQ9]
                cpu_stall   <= 1'b1;
            end else if (read_go) begin
                stall_cnt_q <= `EPC_READ_STALL; // [RQ11]
                cpu_stall   <= 1'b1;
            end else if (stall_cnt_q > 3'h1) begin
                stall_cnt_q <= stall_cnt_q - 3'h1;
            end else begin
                stall_cnt_q <= 3'h0;
                cpu_stall   <= 1'b0;
            end
            // Level while idle; the global enable gates it too.
            ready_irq <= rie_q & global_irq_enable & ~busy & ~prog_go;
            // [RQ4] [RQ5]
            mem_addr  <= addr_q;
            mem_wdata <= data_q;
        end
    end

endmodule

// >>> tb/epc_ctrl_checker.sv
// Checker for the program control block, bound to its ports.
// Assumes one aclk domain with a synchronous active-low aresetn.
`timescale 1ns/100ps
module epc_ctrl_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_wvalid,
    input wire logic       global_irq_enable,
    input wire logic       ready_irq,
    input wire logic       cpu_stall,
    input wire logic [8:0] mem_addr,
    input wire logic       mem_erase,
    input wire logic       mem_write,
    input wire logic       mem_read
);
    logic [2:0] run_q;
    logic       live_q;
    wire logic  start = mem_erase || mem_write;
    // Stall run length; it saturates so a stuck stall cannot wrap to 2.
    always_ff @(posedge aclk) begin
        if (!aresetn || !cpu_stall) begin
            run_q <= 3'h0;
        end else if (run_q != 3'h7) begin
            run_q <= run_q + 3'h1;
        end
    end
    // Low through the edge that releases reset, where past values would
    // still reach back to the unknowns before the first reset edge.
    always_ff @(posedge aclk) begin
        live_q <= aresetn;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !live_q);
    a_irq_gate: assert property (!global_irq_enable |=> !ready_irq)
        else $error("ready request without global enable");
    a_irq_busy: assert property (start |=> !ready_irq [*3])
        else $error("ready request while programming");
    a_stall_len: assert property (
        $fell(cpu_stall) |-> (run_q == 3'h2 || run_q == 3'h4))
        else $error("stall run of wrong length");
    a_prog_stall: assert property (start |-> ##[0:3] cpu_stall)
        else $error("no stall after programming start");
    a_read_stall: assert property (mem_read |-> ##[0:4] cpu_stall)
        else $error("no stall after read strobe");
    a_busy_blocks: assert property (
        start |=> (!mem_read && $stable(mem_addr)) [*8])
        else $error("read or address change while busy");
    a_one_start: assert property (start |=> !start [*8])
        else $error("second start while busy");
    a_addr_cause: assert property ($changed(mem_addr) |->
        ($past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
         || $past(s_axi_wvalid, 3)))
        else $error("address changed without a write");
endmodule

// >>> tb/epc_mem_model.sv
// Byte array standing in for the nonvolatile data memory.
// Assumes one-cycle erase/write pulses and a read sampled next cycle.
`timescale 1ns/100ps
module epc_mem_model (
    input wire logic       aclk,
    input wire logic [8:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic       mem_erase,
    input wire logic       mem_write,
    input wire logic       mem_read,
    output logic [7:0]     mem_rdata
);
    logic [7:0] cell_q [0:511];
    logic       rd_q = 1'b0;
    logic [7:0] junk_q = 8'h5A;
    // Erase sets all ones; a write alone can only clear bits.
    always @(posedge aclk) begin
        rd_q <= mem_read;
        junk_q <= ~junk_q;
        if (mem_write) begin
            cell_q[mem_addr] <= mem_wdata
                & (mem_erase ? 8'hFF : cell_q[mem_addr]);
        end else if (mem_erase) begin
            cell_q[mem_addr] <= 8'hFF;
        end
    end
    // Outside the read window the bus shows a changing pattern.
    assign mem_rdata = (mem_read || rd_q) ? cell_q[mem_addr] : junk_q;
endmodule

// >>> tb/eeprom_program_control_tb.sv
// Self-checking bench for the program control block over AXI4-Lite.
// Assumes the memory model below answers the block's array port.
`timescale 1ns/100ps
`include "epc_defines.svh"
module eeprom_program_control_tb;
    import epc_pkg::*;
    typedef struct {
        epc_mode_e  m;
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } epc_row_s;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        gie = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] rd_v;
    logic [1:0]  rd_r;
    logic [1:0]  wr_r;
    int          bad_count = 0;
    int          n_tests = 0;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic        irq, stall, m_er, m_wr, m_rd;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [8:0]  m_a;
    wire logic [7:0]  m_wd, m_q;
    epc_row_s rows [6] = '{'{EPC_MODE_ATOMIC, 9'h1FF, 8'hA5, 8'hA5},
        '{EPC_MODE_ERASE, 9'h1FF, 8'h00, 8'hFF},
        '{EPC_MODE_WRITE, 9'h1FF, 8'h3C, 8'h3C},
        '{EPC_MODE_WRITE, 9'h1FF, 8'h0F, 8'h0C},
        '{EPC_MODE_RSVD, 9'h1FF, 8'h77, 8'h0C},
        '{EPC_MODE_ATOMIC, 9'h000, 8'h5A, 8'h5A}};
    // Long program times are cut down so the run stays short.
    epc_ctrl #(.CYC_ATOMIC(80), .CYC_SPLIT(40)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .global_irq_enable(gie), .ready_irq(irq),
        .cpu_stall(stall), .mem_addr(m_a), .mem_wdata(m_wd),
        .mem_erase(m_er), .mem_write(m_wr), .mem_read(m_rd),
        .mem_rdata(m_q));
    epc_mem_model i_mem (.aclk(aclk), .mem_addr(m_a), .mem_wdata(m_wd),
        .mem_erase(m_er), .mem_write(m_wr), .mem_read(m_rd),
        .mem_rdata(m_q));
    // Free-running 250 MHz clock.
    initial begin
        forever #2 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string s, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic give_up();
        bad_count++;
        $display("mismatch wait expected answer seen timeout");
        end_sim();
    endtask
    // Both channels are offered together; each drops when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
            wr_r = bresp;
        end while (!bvalid && n < 200);
        if (n >= 200) give_up();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            rd_v = rdata;
            rd_r = rresp;
        end while (!rvalid && n < 200);
        rready <= 1'b0;
        if (n >= 200) give_up();
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            axi_rd(`EPC_OFF_STATUS);
            n++;
        end while (rd_v[0] !== 1'b0 && n < 100);
        if (n >= 100) give_up();
    endtask
    task automatic prog(input epc_mode_e m, input logic [8:0] a, d);
        axi_wr(`EPC_OFF_ADDR, {23'h0, a});
        axi_wr(`EPC_OFF_DATA, {24'h0, d[7:0]});
        axi_wr(`EPC_OFF_CTRL, {26'h0, m, 4'hC});
        axi_wr(`EPC_OFF_CTRL, {26'h0, m, 4'hE});
    endtask
    // Reset, the row table, then the awkward cases.
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`EPC_OFF_DATA);
        check("data rst", {24'h0, `EPC_RST_DATA}, rd_v);
        check("rresp ok", 32'h0, rd_r);
        axi_rd(`EPC_OFF_CTRL);
        check("ctrl rst", 32'h0, rd_v);
        foreach (rows[i]) begin
            prog(rows[i].m, rows[i].a, rows[i].d);
            axi_rd(`EPC_OFF_STATUS);
            check("busy", rows[i].m != EPC_MODE_RSVD, rd_v[0]);
            check("irq", rows[i].m == EPC_MODE_RSVD, irq);
            wait_idle();
            axi_wr(`EPC_OFF_CTRL, 32'h0000_0009);
            axi_rd(`EPC_OFF_DATA);
            check("read", rows[i].q, rd_v);
        end
        // Erase leaves all ones in the cell, so a read strobe that slipped
        // through while busy would overwrite the data register visibly.
        prog(EPC_MODE_ERASE, 9'h055, 8'h11);
        axi_wr(`EPC_OFF_ADDR, 32'h0000_00AA);
        axi_wr(`EPC_OFF_CTRL, 32'h0000_0029);
        wait_idle();
        axi_rd(`EPC_OFF_ADDR);
        check("addr held", 32'h0000_0055, rd_v);
        axi_rd(`EPC_OFF_CTRL);
        check("mode held", 32'h1, rd_v[5:4]);
        axi_rd(`EPC_OFF_DATA);
        check("no read", 32'h0000_0011, rd_v);
        check("irq idle", 32'h1, irq);
        gie <= 1'b0;
        repeat (3) @(posedge aclk);
        check("irq gie", 32'h0, irq);
        gie <= 1'b1;
        axi_wr(`EPC_OFF_CTRL, 32'h0000_0000);
        repeat (3) @(posedge aclk);
        check("irq rie", 32'h0, irq);
        axi_wr(`EPC_OFF_CTRL, 32'h0000_0004);
        repeat (6) @(posedge aclk);
        axi_wr(`EPC_OFF_CTRL, 32'h0000_0002);
        axi_rd(`EPC_OFF_CTRL);
        check("late trig", 32'h0, rd_v[2:1]);
        prog(EPC_MODE_ERASE, 9'h100, 8'h00);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`EPC_OFF_CTRL);
        check("mode kept", 32'h1, rd_v[5:4]);
        wait_idle();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`EPC_OFF_CTRL);
        check("mode rst", 32'h0, rd_v[5:4]);
        axi_rd(8'h10);
        check("unmapped", 32'h2, rd_r);
        axi_wr(8'h10, 32'h0000_00FF);
        check("unmapped wr", 32'h2, wr_r);
        end_sim();
    end
endmodule
bind epc_ctrl epc_ctrl_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_wvalid(s_axi_wvalid), .global_irq_enable(global_irq_enable),
    .ready_irq(ready_irq), .cpu_stall(cpu_stall), .mem_addr(mem_addr),
    .mem_erase(mem_erase), .mem_write(mem_write), .mem_read(mem_read));
